// ==== verilog/dsl_pkg.sv ====
// shared constants, register map and types of the station label sequencer
package dsl_pkg;

  // clock and base tick timing
  localparam int CLK_MHZ  = 100;
  localparam int TICK_US  = 1000;            // default base tick, microseconds
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

  // label and list sizes
  localparam int LAB_LEN   = 8;
  localparam int TXT_MAX   = 255;
  localparam int AF_MAX_A  = 25;
  localparam int GENRE_CNT = 31;
  localparam int GENRE_W   = 5;
  localparam logic [7:0] SPACE = 8'h20;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CFG0  = 8'h04;
  localparam logic [7:0] OFS_PER0  = 8'h08;
  localparam logic [7:0] OFS_CFG1  = 8'h0c;
  localparam logic [7:0] OFS_PER1  = 8'h10;
  localparam logic [7:0] OFS_TEXT  = 8'h14;
  localparam logic [7:0] OFS_DEFHI = 8'h18;
  localparam logic [7:0] OFS_DEFLO = 8'h1c;
  localparam logic [7:0] OFS_AFW   = 8'h20;
  localparam logic [7:0] OFS_AFCNT = 8'h24;
  localparam logic [7:0] OFS_STAT  = 8'h28;
  localparam logic [7:0] OFS_TICK  = 8'h2c;

  // field positions
  localparam int CTRL_GENRE = 0;
  localparam int CTRL_TRAF  = 5;
  localparam int CTRL_MUS   = 6;
  localparam int CTRL_AFB   = 7;
  localparam int CTRL_SEL   = 8;
  localparam int CTRL_RUN   = 9;
  localparam int CFG_MODE   = 0;
  localparam int CFG_REP    = 8;
  localparam int CFG_LEN    = 16;
  localparam int PER_DWELL  = 0;
  localparam int PER_GAP    = 16;
  localparam int TXT_POS    = 8;
  localparam int TXT_ENG    = 16;

  // reset values
  localparam logic [8:0]  CTRL_RST = 9'h000;
  localparam logic [31:0] CFG_RST  = 32'h0000_0100;
  localparam logic [31:0] PER_RST  = 32'h000a_0064;
  localparam logic [63:0] DEF_RST  = 64'h2020_2020_2020_2020;

  // display modes
  localparam logic [1:0] MODE_BLOCK = 2'h0;
  localparam logic [1:0] MODE_CHAR  = 2'h1;
  localparam logic [1:0] MODE_WORD  = 2'h2;
  localparam logic [1:0] MODE_PAD   = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DWELL, ST_GAP} dsl_state_e;

  // byte-lane merge of a bus write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

endpackage : dsl_pkg

// ==== verilog/dsl_mem.sv ====
// simple dual-port memory with registered read data
`timescale 1ns/1ps
module dsl_mem #(
  parameter int DW = 8,
  parameter int AW = 9
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_ff [2**AW];

  // write port
  always_ff @(posedge clk_i) begin
    if (we_i) mem_ff[waddr_i] <= wdata_i;
  end

  // read port, one cycle latency
  always_ff @(posedge clk_i) begin
    rdata_o <= mem_ff[raddr_i];
  end

endmodule : dsl_mem

// ==== verilog/dsl_label_seq.sv ====
// station label sequencer with two scrolling label engines and wishbone registers
//
// Behaviour
// - hold a five-bit programme genre code and drive it out
// - drive the traffic programme flag as configured
// - drive the music/speech flag as configured
// - each message holds up to 255 characters in every mode
// - two engines keep separate settings; writing one leaves the other alone
// - each engine has text, mode, dwell period and repeat count
// - the whole text loop is sent the configured number of times
// - between loops the default label is shown for the gap period
// - mode may change while running; stored text is kept
// - mode 0 advances the window by eight characters
// - mode 1 advances the window by one character
// - mode 2 advances so that words are not split
// - mode 3 scrolls by one with spaces before and after text
// - method A frequency list holds at most 25 entries
// - method B allows longer frequency lists
// - the label window is always eight characters
`timescale 1ns/1ps
module dsl_label_seq #(
  parameter logic [23:0] TICK_DEF = 24'(dsl_pkg::TICK_CYC),
  parameter int          TXT_AW   = 9
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [7:0]                     adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [31:0]                    dat_i,
  output logic      [31:0]                    dat_o,
  output logic                                ack_o,
  output logic      [dsl_pkg::LAB_LEN*8-1:0]  station_name_label_o,
  output logic      [dsl_pkg::GENRE_W-1:0]    programme_genre_code_o,
  output logic                                traffic_programme_flag_o,
  output logic                                music_speech_flag_o,
  output logic                                af_method_b_o,
  output logic      [7:0]                     af_count_o,
  input  wire logic [7:0]                     af_rd_idx_i,
  output logic      [7:0]                     af_code_o,
  output logic                                loop_active_o
);
  import dsl_pkg::*;

  // all checks run on the system clock, quiet during reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  //////////////////////////////////////////////////////////////////////////////
  // register state
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [8:0]  ctrl_ff;
  logic        run_ff;
  logic [31:0] cfg_ff [2];
  logic [31:0] per_ff [2];
  logic [63:0] deflab_ff;
  logic [23:0] tick_ff;
  logic [7:0]  afcnt_ff;

  // engine state
  dsl_state_e  st_ff;
  logic        eng_ff;
  logic [1:0]  wmode_ff;
  logic [8:0]  pos_ff;
  logic [3:0]  fidx_ff;
  logic [3:0]  brk_ff;
  logic        ok_ff;
  logic [63:0] win_ff;
  logic [63:0] lab_ff;
  logic [15:0] tcnt_ff;
  logic [7:0]  rep_ff;
  logic [23:0] tdiv_ff;

  // combinational helpers
  logic        req;
  logic        wr;
  logic [5:0]  wa;
  logic [31:0] nxt_ctrl;
  logic [31:0] nxt_afw;
  logic [31:0] nxt_tick;
  logic [31:0] rv;
  logic        run_set;
  logic        tick_w;
  logic [1:0]  mode;
  logic [7:0]  len;
  logic [7:0]  reps;
  logic [15:0] dwell;
  logic [15:0] gap;
  logic [8:0]  vi;
  logic [8:0]  ti;
  logic        tv;
  logic [7:0]  tchar;
  logic [7:0]  ch;
  logic [3:0]  step;
  logic [8:0]  nxt_pos;
  logic        last;
  logic        rep_last;
  logic        dwell_end;
  logic        gap_end;
  logic        fin;
  logic        adv_w;

  //////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  assign req      = cyc_i & stb_i & ~ack_ff;
  assign wr       = cyc_i & stb_i & we_i & ack_ff;  // write lands on the acked edge
  assign wa       = adr_i[7:2];
  assign nxt_ctrl = merge({23'h0, ctrl_ff}, dat_i, sel_i);
  assign nxt_afw  = merge({24'h0, afcnt_ff}, dat_i, sel_i);
  assign nxt_tick = merge({8'h0, tick_ff}, dat_i, sel_i);
  assign run_set  = wr && (wa == OFS_CTRL[7:2]) && sel_i[1] && dat_i[CTRL_RUN];

  // ack one cycle after the request, registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff  <= req;
      rdat_ff <= rv;
    end
  end

  // read mux, unmapped and write-only words read zero
  always_comb begin
    rv = 32'h0;
    case (wa)
      OFS_CTRL[7:2]:  rv = {22'h0, run_ff, ctrl_ff};
      OFS_CFG0[7:2]:  rv = cfg_ff[0];
      OFS_PER0[7:2]:  rv = per_ff[0];
      OFS_CFG1[7:2]:  rv = cfg_ff[1];
      OFS_PER1[7:2]:  rv = per_ff[1];
      OFS_DEFHI[7:2]: rv = deflab_ff[63:32];
      OFS_DEFLO[7:2]: rv = deflab_ff[31:0];
      OFS_AFCNT[7:2]: rv = {24'h0, afcnt_ff};
      OFS_STAT[7:2]:  rv = {7'h0, pos_ff, rep_ff, 5'h0, eng_ff, st_ff};
      OFS_TICK[7:2]:  rv = {8'h0, tick_ff};
      default:        rv = 32'h0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff   <= CTRL_RST;
      deflab_ff <= DEF_RST;
      tick_ff   <= TICK_DEF;
      afcnt_ff  <= 8'h0;
      for (int e = 0; e < 2; e++) begin
        cfg_ff[e] <= CFG_RST;
        per_ff[e] <= PER_RST;
      end
    end else begin
      if (wr && wa == OFS_CTRL[7:2]) ctrl_ff <= nxt_ctrl[8:0];
      if (wr && wa == OFS_DEFHI[7:2]) deflab_ff[63:32] <= merge(deflab_ff[63:32], dat_i, sel_i);
      if (wr && wa == OFS_DEFLO[7:2]) deflab_ff[31:0] <= merge(deflab_ff[31:0], dat_i, sel_i);
      if (wr && wa == OFS_TICK[7:2]) tick_ff <= nxt_tick[23:0];
      // per-engine words, each decoded on its own offset
      for (int e = 0; e < 2; e++) begin
        if (wr && wa == (e == 0 ? OFS_CFG0[7:2] : OFS_CFG1[7:2]))
          cfg_ff[e] <= merge(cfg_ff[e], dat_i, sel_i);
        if (wr && wa == (e == 0 ? OFS_PER0[7:2] : OFS_PER1[7:2]))
          per_ff[e] <= merge(per_ff[e], dat_i, sel_i);
      end
      // list length: capped under method A, full byte under method B
      if (wr && wa == OFS_AFCNT[7:2]) begin
        if (!ctrl_ff[CTRL_AFB] && nxt_afw[7:0] > 8'(AF_MAX_A))
          afcnt_ff <= 8'(AF_MAX_A);
        else
          afcnt_ff <= nxt_afw[7:0];
      end else if (!ctrl_ff[CTRL_AFB] && afcnt_ff > 8'(AF_MAX_A)) begin
        afcnt_ff <= 8'(AF_MAX_A);
      end
    end
  end

  // run flag: software start wins over end of sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) run_ff <= 1'b0;
    else if (run_set) run_ff <= 1'b1;
    else if (fin) run_ff <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // message text and frequency list memories
  dsl_mem #(.DW(8), .AW(TXT_AW)) u_txt (
    .clk_i   (clk_i),
    .we_i    (wr && wa == OFS_TEXT[7:2] && sel_i[0]),
    .waddr_i ({dat_i[TXT_ENG], dat_i[TXT_POS +: 8]}),
    .wdata_i (dat_i[7:0]),
    .raddr_i ({eng_ff, ti[7:0]}),
    .rdata_o (tchar)
  );

  dsl_mem #(.DW(8), .AW(8)) u_af (
    .clk_i   (clk_i),
    .we_i    (wr && wa == OFS_AFW[7:2] && sel_i[0]),
    .waddr_i (dat_i[TXT_POS +: 8]),
    .wdata_i (dat_i[7:0]),
    .raddr_i (af_rd_idx_i),
    .rdata_o (af_code_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // base tick divider
  assign tick_w = (tdiv_ff == 24'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) tdiv_ff <= 24'h0;
    else if (tick_w) tdiv_ff <= (tick_ff == 24'h0) ? 24'h0 : tick_ff - 24'h1;
    else tdiv_ff <= tdiv_ff - 24'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // live settings of the running engine
  assign mode  = cfg_ff[eng_ff][CFG_MODE +: 2];
  assign len   = cfg_ff[eng_ff][CFG_LEN +: 8];
  assign reps  = cfg_ff[eng_ff][CFG_REP +: 8];
  assign dwell = per_ff[eng_ff][PER_DWELL +: 16];
  assign gap   = per_ff[eng_ff][PER_GAP +: 16];

  // fetch address; mode 3 sees eight leading spaces
  always_comb begin
    vi = pos_ff + {5'h0, fidx_ff};
    if (wmode_ff == MODE_PAD) begin
      ti = vi - 9'h8;
      tv = (vi >= 9'h8) && (ti < {1'b0, len});
    end else begin
      ti = vi;
      tv = vi < {1'b0, len};
    end
  end

  // characters beyond the text become spaces
  assign ch = ok_ff ? tchar : SPACE;

  // window advance per mode
  always_comb begin
    case (wmode_ff)
      MODE_BLOCK: step = 4'h8;
      MODE_WORD:  step = brk_ff;
      default:    step = 4'h1;
    endcase
    nxt_pos = pos_ff + {5'h0, step};
    case (wmode_ff)
      MODE_CHAR: last = ({1'b0, pos_ff} + 10'h8) >= {2'h0, len};
      MODE_PAD:  last = ({1'b0, pos_ff} + 10'h1) >= ({2'h0, len} + 10'h8);
      default:   last = {1'b0, nxt_pos} >= {2'h0, len};
    endcase
  end

  // period ends counted in ticks, zero acts as one
  assign rep_last  = ({1'b0, rep_ff} + 9'h1) >= {1'b0, reps};
  assign dwell_end = tick_w && (({1'b0, tcnt_ff} + 17'h1) >= {1'b0, dwell});
  assign gap_end   = tick_w && (({1'b0, tcnt_ff} + 17'h1) >= {1'b0, gap});
  assign fin       = (st_ff == ST_DWELL) && dwell_end && last && rep_last;
  assign adv_w     = (st_ff == ST_DWELL) && dwell_end && !last;

  //////////////////////////////////////////////////////////////////////////////
  // sequencing state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff    <= ST_IDLE;
      eng_ff   <= 1'b0;
      wmode_ff <= MODE_BLOCK;
      pos_ff   <= 9'h0;
      fidx_ff  <= 4'h0;
      brk_ff   <= 4'h8;
      win_ff   <= DEF_RST;
      lab_ff   <= DEF_RST;
      tcnt_ff  <= 16'h0;
      rep_ff   <= 8'h0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          lab_ff <= deflab_ff;
          if (run_ff) begin
            eng_ff   <= ctrl_ff[CTRL_SEL];
            wmode_ff <= cfg_ff[ctrl_ff[CTRL_SEL]][CFG_MODE +: 2];
            pos_ff   <= 9'h0;
            rep_ff   <= 8'h0;
            fidx_ff  <= 4'h0;
            brk_ff   <= 4'h8;
            st_ff    <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // one read per cycle, data lands one cycle later
          fidx_ff <= fidx_ff + 4'h1;
          if (fidx_ff != 4'h0) win_ff <= {win_ff[55:0], ch};
          if (fidx_ff >= 4'h2 && ch == SPACE) brk_ff <= fidx_ff;
          if (fidx_ff == 4'h8) begin
            lab_ff  <= {win_ff[55:0], ch};
            tcnt_ff <= 16'h0;
            st_ff   <= ST_DWELL;
          end
        end
        ST_DWELL: begin
          if (dwell_end) begin
            tcnt_ff <= 16'h0;
            if (!last) begin
              pos_ff   <= nxt_pos;
              wmode_ff <= mode;
              fidx_ff  <= 4'h0;
              brk_ff   <= 4'h8;
              st_ff    <= ST_FETCH;
            end else if (rep_last) begin
              lab_ff <= deflab_ff;
              st_ff  <= ST_IDLE;
            end else begin
              lab_ff <= deflab_ff;
              rep_ff <= rep_ff + 8'h1;
              st_ff  <= ST_GAP;
            end
          end else if (tick_w) begin
            tcnt_ff <= tcnt_ff + 16'h1;
          end
        end
        ST_GAP: begin
          lab_ff <= deflab_ff;
          if (gap_end) begin
            pos_ff   <= 9'h0;
            wmode_ff <= mode;
            fidx_ff  <= 4'h0;
            brk_ff   <= 4'h8;
            st_ff    <= ST_FETCH;
          end else if (tick_w) begin
            tcnt_ff <= tcnt_ff + 16'h1;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // read-ahead validity follows the memory latency
  always_ff @(posedge clk_i) begin
    if (rst_i) ok_ff <= 1'b0;
    else ok_ff <= tv;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign dat_o                    = rdat_ff;
  assign ack_o                    = ack_ff;
  assign station_name_label_o     = lab_ff;
  assign programme_genre_code_o   = ctrl_ff[CTRL_GENRE +: GENRE_W];
  assign traffic_programme_flag_o = ctrl_ff[CTRL_TRAF];
  assign music_speech_flag_o      = ctrl_ff[CTRL_MUS];
  assign af_method_b_o            = ctrl_ff[CTRL_AFB];
  assign af_count_o               = afcnt_ff;
  assign loop_active_o            = run_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  block_step_a: assert property (adv_w && wmode_ff == MODE_BLOCK |=>
    pos_ff == $past(pos_ff) + 9'h8) else $error("mode 0 step not eight");
  char_step_a: assert property (adv_w && wmode_ff == MODE_CHAR |=>
    pos_ff == $past(pos_ff) + 9'h1) else $error("mode 1 step not one");
  word_step_a: assert property (adv_w && wmode_ff == MODE_WORD |=>
    (pos_ff - $past(pos_ff)) >= 9'h2 && (pos_ff - $past(pos_ff)) <= 9'h8)
    else $error("mode 2 step out of range");
  pad_lead_a: assert property (st_ff == ST_DWELL && wmode_ff == MODE_PAD
    && pos_ff < 9'h8 |-> lab_ff[63:56] == SPACE) else $error("mode 3 lead not space");
  tail_space_a: assert property (st_ff == ST_DWELL && wmode_ff != MODE_PAD
    && $stable(len) && ({1'b0, pos_ff} + 10'h7) >= {2'h0, len} |-> lab_ff[7:0] == SPACE)
    else $error("tail past text not space");
  gap_label_a: assert property (st_ff == ST_GAP && $past(st_ff) == ST_GAP
    && $stable(deflab_ff) |-> lab_ff == deflab_ff) else $error("gap label not default");
  rep_done_a: assert property (fin && !run_set |=> st_ff == ST_IDLE && !run_ff)
    else $error("sequence did not finish");
  eng_indep_a: assert property (wr && wa == OFS_CFG0[7:2] |=> $stable(cfg_ff[1]))
    else $error("engine two changed by engine one write");
  af_cap_a: assert property (!ctrl_ff[CTRL_AFB] |=> afcnt_ff <= 8'(AF_MAX_A))
    else $error("method A list above limit");
  tick_gap_a: assert property (tick_w && tick_ff > 24'h1 && $stable(tick_ff) |=> !tick_w)
    else $error("tick too frequent");

endmodule : dsl_label_seq

// ==== tb/dsl_group_sink.sv ====
// model of the group builder: reads the frequency list and logs label changes
`timescale 1ns/1ps
module dsl_group_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clr_i,
  input  wire logic [63:0] label_i,
  input  wire logic [7:0]  af_code_i,
  output logic      [7:0]  af_rd_idx_o
);
  logic [63:0] labels [$];
  logic [63:0] last_lab;
  logic [7:0]  af_seen [0:255];
  logic [7:0]  idx_q;

  ////////////////////////////////////////////////////////////////////////////
  // sweep the list index; each code answers one cycle after its index
  always @(posedge clk_i) begin
    if (rst_i) begin
      af_rd_idx_o <= 8'h00;
      idx_q       <= 8'h00;
    end else begin
      af_rd_idx_o      <= af_rd_idx_o + 8'h01;
      idx_q            <= af_rd_idx_o;
      af_seen[idx_q]   <= af_code_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // log every new label that receivers would be sent
  always @(posedge clk_i) begin
    if (clr_i) begin
      labels.delete();
      last_lab <= label_i;
    end else if (label_i !== last_lab) begin
      labels.push_back(label_i);
      last_lab <= label_i;
    end
  end
endmodule : dsl_group_sink

// ==== tb/test_dsl_label_seq.sv ====
// self-checking bench of the station label sequencer
`timescale 1ns/1ps
module test_dsl_label_seq;
  import dsl_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic        clr   = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd, junk;
  logic        ack_o, traf, mus, afb, active;
  logic [63:0] label;
  logic [63:0] defl  = "DFLTLBL!";
  logic [4:0]  genre;
  logic [7:0]  afcnt, af_idx, af_code;
  logic [7:0]  txt [0:1][0:254];
  int          len [2];
  int          miscompares = 0;
  int          tests_run = 0;
  string       s = "AB CDEFG HIJ";

  always #5 clk_i = ~clk_i;

  dsl_label_seq #(.TICK_DEF(24'd4)) i_dsl_label_seq (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .station_name_label_o(label), .programme_genre_code_o(genre),
    .traffic_programme_flag_o(traf), .music_speech_flag_o(mus),
    .af_method_b_o(afb), .af_count_o(afcnt), .af_rd_idx_i(af_idx),
    .af_code_o(af_code), .loop_active_o(active));

  dsl_group_sink i_dsl_group_sink (
    .clk_i(clk_i), .rst_i(rst_i), .clr_i(clr), .label_i(label),
    .af_code_i(af_code), .af_rd_idx_o(af_idx));

  ////////////////////////////////////////////////////////////////////////////
  // compare tasks, bus cycles and verdict
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task chk_label(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_label

  task wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 1000);
    if (n >= 1000) chk_word("ack", 32'h1, 32'(ack_o));
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb_cycle

  task wb_write(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d, junk);
  endtask : wb_write

  task wb_read(input logic [7:0] a);
    wb_cycle(1'b0, a, 32'h0, rd);
  endtask : wb_read

  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // expected window contents; mode 3 has eight spaces ahead of the text
  function automatic logic [7:0] vch(int e, int m, int i);
    int j;
    j = (m == 3) ? i - 8 : i;
    return (j >= 0 && j < len[e]) ? txt[e][j] : SPACE;
  endfunction : vch

  function automatic logic [63:0] win(int e, int m, int p);
    logic [63:0] w;
    for (int k = 0; k < 8; k++) w[63-8*k -: 8] = vch(e, m, p + k);
    return w;
  endfunction : win

  // run one engine and compare the label sequence the sink logged
  task automatic run_eng(input int e, input int m, input int rep);
    logic [63:0] exp [$];
    logic [63:0] prev;
    int          p, nx, n;
    bit          fin;
    wb_write(e ? OFS_CFG1 : OFS_CFG0, {8'h0, 8'(len[e]), 8'(rep), 6'h0, 2'(m)});
    @(posedge clk_i) clr <= 1'b1;
    @(posedge clk_i) clr <= 1'b0;
    prev = label;
    wb_write(OFS_CTRL, 32'h200 | (32'(e) << 8));
    @(posedge clk_i);
    chk_word("running", 32'h1, 32'(active));
    n = 0;
    while (active === 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    for (int r = 0; r < rep; r++) begin
      if (r > 0) exp.push_back(defl);
      p = 0;
      fin = 1'b0;
      while (!fin) begin
        exp.push_back(win(e, m, p));
        nx = p + ((m == 0 || m == 2) ? 8 : 1);
        for (int k = 1; k < 8; k++) if (m == 2 && vch(e, m, p + k) == SPACE) nx = p + k + 1;
        fin = (m == 1) ? (p + 8 >= len[e]) : (m == 3) ? (p + 1 >= len[e] + 8) : (nx >= len[e]);
        p = nx;
      end
    end
    n = 0;
    foreach (exp[i]) begin
      if (exp[i] !== prev) begin
        chk_label("window", exp[i], (n < i_dsl_group_sink.labels.size()) ?
                  i_dsl_group_sink.labels[n] : 64'hx);
        n++;
        prev = exp[i];
      end
    end
    // the return to the default label is logged once more
    @(posedge clk_i);
    chk_word("label count", 32'(n + 1), 32'(i_dsl_group_sink.labels.size()));
    $display("test engine %0d mode %0d done", e, m);
  endtask : run_eng

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_label("reset label", DEF_RST, label);
    wb_read(OFS_CFG0);
    chk_word("cfg0", CFG_RST, rd);
    wb_read(OFS_PER1);
    chk_word("per1", PER_RST, rd);
    wb_read(OFS_TICK);
    chk_word("tick", 32'd4, rd);
    wb_read(OFS_TEXT);
    chk_word("text read", 32'h0, rd);
    wb_read(8'h3c);
    chk_word("unmapped", 32'h0, rd);
    $display("test reset done");
    for (int g = 0; g < GENRE_CNT; g += 15) begin
      wb_write(OFS_CTRL, 32'(g) | 32'h60);
      @(posedge clk_i);
      chk_word("genre", 32'(g), 32'(genre));
      chk_word("traffic", 32'h1, 32'(traf));
      chk_word("music", 32'h1, 32'(mus));
    end
    wb_write(OFS_AFCNT, 32'd30);
    wb_read(OFS_AFCNT);
    chk_word("afcnt a", 32'(AF_MAX_A), rd);
    chk_word("afcnt pin", 32'(AF_MAX_A), 32'(afcnt));
    wb_write(OFS_CTRL, 32'h80);
    wb_write(OFS_AFCNT, 32'd30);
    wb_read(OFS_AFCNT);
    chk_word("afcnt b", 32'd30, rd);
    chk_word("method b", 32'h1, 32'(afb));
    chk_word("flags off", 32'h0, {30'h0, traf, mus});
    wb_write(OFS_AFW, 32'h035a);
    repeat (300) @(posedge clk_i);
    chk_word("af code", 32'h5a, 32'(i_dsl_group_sink.af_seen[3]));
    $display("test fields done");
    wb_write(OFS_CFG1, 32'h00ff_0303);
    wb_read(OFS_CFG0);
    chk_word("cfg0 kept", CFG_RST, rd);
    wb_write(OFS_DEFHI, defl[63:32]);
    wb_write(OFS_DEFLO, defl[31:0]);
    wb_write(OFS_PER0, 32'h0002_0001);
    wb_write(OFS_PER1, 32'h0002_0001);
    len[0] = s.len();
    len[1] = TXT_MAX;
    for (int i = 0; i < len[0]; i++) begin
      txt[0][i] = s[i];
      wb_write(OFS_TEXT, {15'h0, 1'b0, 8'(i), s[i]});
    end
    for (int i = 0; i < len[1]; i++) begin
      txt[1][i] = 8'h61 + 8'(i % 26);
      wb_write(OFS_TEXT, {15'h0, 1'b1, 8'(i), txt[1][i]});
    end
    for (int m = 0; m < 4; m++) run_eng(0, m, (m == 0) ? 2 : 1);
    run_eng(1, 0, 1);
    run_eng(0, 1, 1);
    test_done();
  end

  // watchdog against a hung bus or sequence
  initial begin
    #500_000;
    miscompares++;
    test_done();
  end
endmodule : test_dsl_label_seq
